// ==== bench/plane_memory.sv ====
// Purpose: Display memory answering plane DMA reads.
// Assumes: Ack and data come in the cycle the request is taken.
// Notes:   Slow mode waits 0 to 3 cycles; idle data is the last answer inverted.
`timescale 1ns/1ps
module plane_memory (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request side
    input wire scroll_pkg::dma_req_t dma_req,
    input wire logic slow,
    input wire logic [15:0] pattern,
    // Answer side
    output logic dma_ack,
    output logic [15:0] dma_rdata
);
    int wait_left;
    logic [15:0] last_q;
    assign dma_ack = dma_req.valid && wait_left == 0;
    // Not the held value outside an answer, so stale data cannot pass
    assign dma_rdata = dma_ack ? pattern : ~last_q;
    always @(posedge clk) begin
        if (!rst_n) begin
            wait_left <= 0;
            last_q <= 16'h0000;
        end else if (dma_ack) begin
            wait_left <= slow ? int'($urandom % 4) : 0;
            last_q <= pattern;
        end else if (dma_req.valid && wait_left > 0) begin
            wait_left <= wait_left - 1;
        end
    end
endmodule : plane_memory

// ==== bench/playfield_scroll_fetch_tb.sv ====
// Purpose: Self-checking bench for fetch, modulo, clamps and scroll delay.
// Assumes: Two planes; line of 908 clocks; constant plane data.
// Notes:   Field reload is beyond run length; live pointers are read back.
`timescale 1ns/1ps
module playfield_scroll_fetch_tb;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, slow, dma_ack;
    logic pixel_valid, sprite7_lost, mon_on, cmp_on, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] dma_rdata, pat;
    logic [2:0] pf1_pixel, pf2_pixel;
    logic [63:0] h1, h2;
    logic [31:0] exp_a [6];
    logic [15:0] modv [2];
    int cnt [6];
    int fail_count, n_compared, nwords, lines, shift, run;
    scroll_pkg::dma_req_t dma_req;

    playfield_scroll_fetch u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dma_req(dma_req), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
        .pf1_pixel(pf1_pixel), .pf2_pixel(pf2_pixel), .pixel_valid(pixel_valid),
        .sprite7_lost(sprite7_lost));
    plane_memory u_mem (.clk(clk), .rst_n(rst_n), .dma_req(dma_req), .slow(slow),
        .pattern(pat), .dma_ack(dma_ack), .dma_rdata(dma_rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    task conclude;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Early in a line, before any fetch window can open
    task line_start;
        int n;
        n = 0;
        do begin
            apb(1'b0, scroll_pkg::STATUS_ADDR, 32'h0000_0000);
            n++;
        end while (rd[7:0] >= 8'h08 && n < 600);
        if (n >= 600) begin
            fail_count++;
            conclude();
        end
    endtask : line_start

    task fetch_run(input logic [7:0] fs, input logic [7:0] fe, input logic [7:0] c);
        int e;
        int n;
        e = int'(fs < 8'h18 ? 8'h18 : fs) - (c[2] ? 8 : 0);
        nwords = (int'(fe > 8'hd8 ? 8'hd8 : fe) - e) / 8 + 1;
        modv[0] = 16'(($urandom % 32) * 2 + (c[2] ? 2 : 0));
        modv[1] = 16'(($urandom % 32) * 2 + (c[2] ? 2 : 0));
        slow <= c[2];
        apb(1'b1, scroll_pkg::FSTART_ADDR, {24'h0, fs});
        apb(1'b1, scroll_pkg::FSTOP_ADDR, {24'h0, fe});
        apb(1'b1, scroll_pkg::ODD_MOD_ADDR, {16'h0, modv[0]});
        apb(1'b1, scroll_pkg::EVEN_MOD_ADDR, {16'h0, modv[1]});
        line_start();
        for (int p = 0; p < 2; p++) begin
            apb(1'b0, scroll_pkg::PTR_BASE_ADDR + 32'(4 * p), 32'h0);
            exp_a[p] = rd;
            cnt[p] = 0;
        end
        apb(1'b1, scroll_pkg::CTRL_ADDR, {24'h0, c});
        lines = 0;
        mon_on = 1'b1;
        n = 0;
        while (lines < 2 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        chk(lines >= 2, "line fetch stalled");
        chk(sprite7_lost === (c[0] && e < 56), "sprite 7 loss");
        mon_on = 1'b0;
        apb(1'b1, scroll_pkg::CTRL_ADDR, 32'h0000_0000);
    endtask : fetch_run

    always @(posedge clk) begin
        if (mon_on && dma_req.valid && dma_ack) begin
            chk(dma_req.addr === exp_a[dma_req.plane], "plane address");
            exp_a[dma_req.plane] += 2;
            cnt[dma_req.plane]++;
            if (cnt[dma_req.plane] == nwords) begin
                // Odd planes are indices 0, 2 and 4
                exp_a[dma_req.plane] +=
                    {{16{modv[dma_req.plane[0]][15]}}, modv[dma_req.plane[0]]};
                cnt[dma_req.plane] = 0;
                if (dma_req.plane == 3'd0) lines++;
            end
        end
        h1 = {h1[62:0], pf1_pixel[0]};
        h2 = {h2[62:0], pf2_pixel[0]};
        run = pixel_valid === 1'b1 ? run + 1 : 0;
        if (cmp_on && run > 80) begin
            if (shift >= 0) chk(h2[0] === h1[shift], "playfield 2 delay");
            else chk(h1[0] === h2[-shift], "playfield 1 delay");
        end
    end

    logic [31:0] ra [6];
    logic [31:0] rv [6];
    logic [7:0] dv [6];
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, slow, mon_on, cmp_on} = 6'b00_0000;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        pat = 16'hf0c3;
        {h1, h2} = 128'h0;
        {fail_count, n_compared, shift, run} = 128'h0;
        ra = '{scroll_pkg::CTRL_ADDR, scroll_pkg::FSTART_ADDR, scroll_pkg::FSTOP_ADDR,
            scroll_pkg::ODD_MOD_ADDR, scroll_pkg::SCROLL_DELAY_ADDR, 32'h0000_0040};
        rv = '{32'h0000_0000, 32'h0000_0038, 32'h0000_00d0, 32'h0, 32'h0, 32'h0};
        dv = '{8'h00, 8'h50, 8'h05, 8'hf0, 8'h3c, 8'h72};
        void'($urandom(32'h341c_d002));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b1, scroll_pkg::SCROLL_DELAY_ADDR, 32'h0000_0077);
        // Start stepped two 40-byte lines on; only used at the next field
        apb(1'b1, scroll_pkg::PTR_BASE_ADDR, 32'h0000_0050);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ra[i], 32'h0000_0000);
            chk(rd === rv[i] && err === (i == 5), "register read");
        end
        fetch_run(8'h38, 8'hd0, 8'h21);
        fetch_run(8'h38, 8'hd0, 8'h25);
        fetch_run(8'h08, 8'hf0, 8'h21);
        for (int i = 0; i < 6; i++) begin
            // Last entry runs hires, where each step is two hires pixels
            apb(1'b1, scroll_pkg::CTRL_ADDR, i == 5 ? 32'h0000_0023 : 32'h0000_0021);
            apb(1'b1, scroll_pkg::SCROLL_DELAY_ADDR, {24'h0, dv[i]});
            shift = 2 * (int'(dv[i][7:4]) - int'(dv[i][3:0]));
            repeat (1000) @(posedge clk);
            cmp_on = 1'b1;
            repeat (1000) @(posedge clk);
            cmp_on = 1'b0;
        end
        conclude();
    end
endmodule : playfield_scroll_fetch_tb

// ==== bench/scroll_monitor.sv ====
// Purpose: Port checker for the playfield scroll and fetch block.
// Assumes: Zero-wait APB slave; one clock domain.
// Notes:   Attached to every instance of the top by the bind at the foot.
`timescale 1ns/1ps
module scroll_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // DMA and pixels
    input wire scroll_pkg::dma_req_t dma_req,
    input wire logic dma_ack,
    input wire logic pixel_valid,
    input wire logic sprite7_lost
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    delay_write_only_a: assert property (
        psel && penable && !pwrite && paddr == scroll_pkg::SCROLL_DELAY_ADDR |-> prdata == 0)
        else $error("scroll delay read not zero");
    unmapped_error_a: assert property (
        psel && penable && paddr == 32'h0000_0040 |-> pslverr && pready)
        else $error("unmapped access not refused");
    sprite_cause_a: assert property (
        $rose(sprite7_lost) |-> $past(psel && penable && pwrite))
        else $error("sprite loss without register write");
    dma_hold_a: assert property (
        dma_req.valid && !dma_ack |=> dma_req.valid && $stable(dma_req.addr))
        else $error("dma request dropped or changed");
    plane_order_a: assert property (
        dma_req.valid && dma_ack |=> !dma_req.valid
        || dma_req.plane == 3'($past(dma_req.plane) + 3'd1))
        else $error("plane order broken");
    word_addr_a: assert property (dma_req.valid |-> !dma_req.addr[0])
        else $error("odd dma address");
    plane_range_a: assert property (dma_req.valid |-> dma_req.plane < 3'd6)
        else $error("plane out of range");
    pixel_word_a: assert property ($rose(pixel_valid) |-> pixel_valid [*8])
        else $error("pixel word cut short");
endmodule : scroll_monitor

bind playfield_scroll_fetch scroll_monitor u_mon (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_req(dma_req), .dma_ack(dma_ack), .pixel_valid(pixel_valid),
    .sprite7_lost(sprite7_lost));

// ==== hdl/plane_delay_line.sv ====
// Purpose: Serialises three plane words of one playfield and delays them by 0 to 31 pixels.
// Assumes: Load comes on the shift that ends a 16-pixel word.
// Notes:   Bits held in the history line are those of the previous word, shown late.
`timescale 1ns/1ps
module plane_delay_line (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pixel stream control
    input wire logic shift,
    input wire logic load,
    input wire logic [2:0][15:0] word,
    input wire logic [4:0] delay,
    // Pixel out
    output logic [2:0] pix
);
    typedef struct packed {
        logic [2:0][15:0] cur;
        logic [2:0][30:0] hist;
        logic [2:0] pix;
    } dl_state_t;

    dl_state_t s_q, s_d;

    assign pix = s_q.pix;

    always_comb begin
        s_d = s_q;
        if (shift) begin
            for (int p = 0; p < 3; p++) begin
                // Tap zero is the live bit, so no delay costs no pixel
                s_d.pix[p] = (delay == 5'd0) ? s_q.cur[p][15] : s_q.hist[p][delay - 5'd1];
                s_d.hist[p] = {s_q.hist[p][29:0], s_q.cur[p][15]};
                s_d.cur[p] = load ? word[p] : {s_q.cur[p][14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : plane_delay_line

// ==== hdl/playfield_scroll_fetch.sv ====
// Purpose: Bit-plane fetch, modulo and scroll delay for a two-playfield display.
// Assumes: Memory answers a read with dma_ack and data in the same cycle.
// Notes:   Colour lookup and display window decode sit outside this block.
//
// Overview of operation
// - Each field after the first starts from the plane pointers software loaded.
// - For a fetch start of 20 or later, one extra word per line (two in hires) is fetched left of the window and held.
// - Each playfield's pixels are delayed right by 0 to 15 pixels.
// - In hires the delay steps are two hires pixels.
// - Delay bits 3-0 serve playfield 1, bits 7-4 playfield 2.
// - Scrolling moves a fetch start of 20 or later one lores word (8 colour clocks) earlier; stop stays put.
// - Fetch start before the normal position costs sprite channel 7.
// - One fetch start and stop pair governs both playfields.
// - After the last word, pointer is one word on and the modulo is added.
// - The modulo added belongs to the plane being advanced.
// - Two modulo registers: odd planes and even planes.
// - Fetch start clamps to no earlier than 18, stop no later than D8.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module playfield_scroll_fetch (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Plane DMA
    output scroll_pkg::dma_req_t dma_req,
    input wire logic dma_ack,
    input wire logic [15:0] dma_rdata,
    // Pixels and status
    output logic [2:0] pf1_pixel,
    output logic [2:0] pf2_pixel,
    output logic pixel_valid,
    output logic sprite7_lost
);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {
        FS_IDLE = 2'b00,
        FS_REQ = 2'b01
    } fetch_state_t;

    typedef struct packed {
        logic [15:0] delay_reg;
        logic [7:0] ctrl;
        logic [7:0] fstart;
        logic [7:0] fstop;
        logic [15:0] odd_mod;
        logic [15:0] even_mod;
        logic [5:0][31:0] start_ptr;
        logic [5:0][31:0] ptr;
        logic [1:0] sub;
        logic [7:0] hpos;
        logic [8:0] vpos;
        fetch_state_t fst;
        logic [2:0] fidx;
        logic [5:0][15:0] pbuf;
        logic buf_full;
        logic [3:0] px_cnt;
        logic px_phase;
        logic shown;
        logic [7:0] line_delay;
        logic [31:0] prdata;
    } state_t;

    state_t s_q, s_d;

    // ************************************************************
    // Derived control
    // ************************************************************
    logic hires, dma_en, extra;
    logic [2:0] nplanes;
    logic [7:0] unit, start_c, stop_c, eff_start, rel;
    logic setup, access, wr_acc, mapped;
    logic line_end, field_end, line_start, fetch_tick;
    logic shift, word_end, do_load;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    scroll_pkg::fetch_word_t fifo_in, fifo_out;
    logic [2:0][15:0] pf1_word, pf2_word;
    logic [4:0] pf1_delay, pf2_delay;

    assign hires = s_q.ctrl[scroll_pkg::CTRL_HIRES];
    assign dma_en = s_q.ctrl[scroll_pkg::CTRL_DMA_EN];
    assign extra = s_q.ctrl[scroll_pkg::CTRL_EXTRA];
    assign nplanes = s_q.ctrl[scroll_pkg::CTRL_NPL_LSB +: 3];
    assign unit = hires ? scroll_pkg::HIRES_UNIT : scroll_pkg::LORES_UNIT;

    // One start/stop pair for both playfields, held inside the legal range
    always_comb begin
        start_c = s_q.fstart;
        stop_c = s_q.fstop;
        if (start_c < scroll_pkg::FETCH_MIN) begin
            start_c = scroll_pkg::FETCH_MIN;
        end
        if (stop_c > scroll_pkg::FETCH_MAX) begin
            stop_c = scroll_pkg::FETCH_MAX;
        end
        // Extra scroll word: start one lores word early if that stays at or after 18, stop unchanged
        eff_start = start_c;
        if (extra && (start_c >= scroll_pkg::FETCH_MIN + scroll_pkg::LORES_UNIT)) begin
            eff_start = start_c - scroll_pkg::LORES_UNIT;
        end
    end

    // Early start steals the DMA slot of the last sprite channel
    assign sprite7_lost = dma_en && (eff_start < scroll_pkg::FETCH_NORMAL);

    // ************************************************************
    // Raster timing
    // ************************************************************
    assign line_end = (s_q.hpos == scroll_pkg::LINE_LAST) && (s_q.sub == 2'b11);
    assign field_end = line_end && (s_q.vpos == scroll_pkg::FIELD_LAST);
    assign line_start = (s_q.hpos == 8'h00) && (s_q.sub == 2'b00);
    assign rel = s_q.hpos - eff_start;
    // The stop position itself still fetches its word, so one word at the D8 limit
    assign fetch_tick = dma_en && (nplanes != 3'd0) && (s_q.sub == 2'b00)
        && (s_q.hpos >= eff_start) && (s_q.hpos <= stop_c)
        && ((rel & (unit - 8'h01)) == 8'h00);

    // ************************************************************
    // APB decode
    // ************************************************************
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_acc = access && pwrite;
    assign pready = access;

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            scroll_pkg::CTRL_ADDR,
            scroll_pkg::FSTART_ADDR,
            scroll_pkg::FSTOP_ADDR,
            scroll_pkg::ODD_MOD_ADDR,
            scroll_pkg::EVEN_MOD_ADDR,
            scroll_pkg::STATUS_ADDR,
            scroll_pkg::SCROLL_DELAY_ADDR: mapped = 1'b1;
            default: begin
                mapped = (paddr >= scroll_pkg::PTR_BASE_ADDR)
                    && (paddr <= scroll_pkg::PTR_LAST_ADDR) && (paddr[1:0] == 2'b00);
            end
        endcase
    end

    assign pslverr = access && !mapped;
    assign prdata = s_q.prdata;

    // ************************************************************
    // Fetch FIFO and display pipeline
    // ************************************************************
    assign dma_req = '{valid: (s_q.fst == FS_REQ) && fifo_in_ready, plane: s_q.fidx,
        addr: s_q.ptr[s_q.fidx]};
    assign fifo_in = '{plane: s_q.fidx, data: dma_rdata};
    assign fifo_out_ready = !s_q.buf_full;

    assign shift = hires || s_q.px_phase;
    assign word_end = shift && (s_q.px_cnt == 4'hf);
    assign do_load = word_end;
    assign pixel_valid = s_q.shown;

    word_fifo #(
        .W($bits(scroll_pkg::fetch_word_t)),
        .DEPTH(scroll_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(dma_req.valid && dma_ack),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    // Odd planes (1,3,5) feed playfield 1, even planes playfield 2
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            pf1_word[p] = s_q.buf_full ? s_q.pbuf[2 * p] : 16'h0000;
            pf2_word[p] = s_q.buf_full ? s_q.pbuf[2 * p + 1] : 16'h0000;
        end
        // Hires counts delay in pairs of hires pixels
        pf1_delay = hires ? {s_q.line_delay[3:0], 1'b0} : {1'b0, s_q.line_delay[3:0]};
        pf2_delay = hires ? {s_q.line_delay[7:4], 1'b0} : {1'b0, s_q.line_delay[7:4]};
    end

    plane_delay_line u_pf1 (
        .clk(clk),
        .rst_n(rst_n),
        .shift(shift),
        .load(do_load),
        .word(pf1_word),
        .delay(pf1_delay),
        .pix(pf1_pixel)
    );

    plane_delay_line u_pf2 (
        .clk(clk),
        .rst_n(rst_n),
        .shift(shift),
        .load(do_load),
        .word(pf2_word),
        .delay(pf2_delay),
        .pix(pf2_pixel)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;

        // Register writes take effect at the access edge
        if (wr_acc && mapped) begin
            case (paddr)
                scroll_pkg::CTRL_ADDR: s_d.ctrl = pwdata[7:0];
                scroll_pkg::FSTART_ADDR: s_d.fstart = pwdata[7:0];
                scroll_pkg::FSTOP_ADDR: s_d.fstop = pwdata[7:0];
                scroll_pkg::ODD_MOD_ADDR: s_d.odd_mod = pwdata[15:0];
                scroll_pkg::EVEN_MOD_ADDR: s_d.even_mod = pwdata[15:0];
                scroll_pkg::SCROLL_DELAY_ADDR: s_d.delay_reg = pwdata[15:0];
                scroll_pkg::STATUS_ADDR: s_d.ctrl = s_q.ctrl;
                default: s_d.start_ptr[paddr[4:2] - 3'd0] = pwdata;
            endcase
        end

        // Read data is captured in the setup phase; the delay register is write-only
        if (setup) begin
            case (paddr)
                scroll_pkg::CTRL_ADDR: s_d.prdata = {24'h00_0000, s_q.ctrl};
                scroll_pkg::FSTART_ADDR: s_d.prdata = {24'h00_0000, s_q.fstart};
                scroll_pkg::FSTOP_ADDR: s_d.prdata = {24'h00_0000, s_q.fstop};
                scroll_pkg::ODD_MOD_ADDR: s_d.prdata = {16'h0000, s_q.odd_mod};
                scroll_pkg::EVEN_MOD_ADDR: s_d.prdata = {16'h0000, s_q.even_mod};
                scroll_pkg::STATUS_ADDR: begin
                    s_d.prdata = {12'h000, sprite7_lost, s_q.buf_full, s_q.fst == FS_REQ,
                        s_q.vpos, s_q.hpos};
                end
                default: begin
                    s_d.prdata = 32'h0000_0000;
                    if (mapped && (paddr != scroll_pkg::SCROLL_DELAY_ADDR)) begin
                        s_d.prdata = s_q.ptr[paddr[4:2]];
                    end
                end
            endcase
        end

        // Raster counters
        s_d.sub = s_q.sub + 2'b01;
        if (s_q.sub == 2'b11) begin
            s_d.hpos = line_end ? 8'h00 : s_q.hpos + 8'h01;
        end
        if (line_end) begin
            s_d.vpos = field_end ? 9'h000 : s_q.vpos + 9'h001;
        end

        // Delay is only sampled at line start, so no line mixes two settings
        if (line_start) begin
            s_d.line_delay = s_q.delay_reg[7:0];
        end

        // Fetch sequencer: one word per active plane each fetch unit
        case (s_q.fst)
            FS_IDLE: begin
                if (fetch_tick) begin
                    s_d.fst = FS_REQ;
                    s_d.fidx = 3'd0;
                end
            end
            FS_REQ: begin
                if (dma_req.valid && dma_ack) begin
                    s_d.ptr[s_q.fidx] = s_q.ptr[s_q.fidx] + 32'h0000_0002;
                    s_d.fidx = s_q.fidx + 3'd1;
                    if (s_q.fidx + 3'd1 >= nplanes) begin
                        s_d.fst = FS_IDLE;
                    end
                end
            end
            default: s_d.fst = FS_IDLE;
        endcase

        // End of line: pointers already sit one word past the last fetch
        if (line_end) begin
            s_d.fst = FS_IDLE;
            for (int p = 0; p < scroll_pkg::PLANES; p++) begin
                if (p % 2 == 0) begin
                    s_d.ptr[p] = s_q.ptr[p] + {{16{s_q.odd_mod[15]}}, s_q.odd_mod};
                end else begin
                    s_d.ptr[p] = s_q.ptr[p] + {{16{s_q.even_mod[15]}}, s_q.even_mod};
                end
            end
        end
        // Each field restarts at the loaded pointers; moving them scrolls vertically
        if (field_end) begin
            s_d.ptr = s_q.start_ptr;
        end

        // A word boundary frees the buffer; a gather ending in that cycle wins
        if (word_end) begin
            s_d.buf_full = 1'b0;
        end
        // Gather one word of every plane before the serialisers take them
        if (fifo_out_valid && !s_q.buf_full) begin
            s_d.pbuf[fifo_out.plane] = fifo_out.data;
            if (fifo_out.plane + 3'd1 >= nplanes) begin
                s_d.buf_full = 1'b1;
            end
        end

        // Pixel timing; the extra word only reaches the screen through the delay
        s_d.px_phase = !s_q.px_phase;
        if (shift) begin
            s_d.px_cnt = s_q.px_cnt + 4'h1;
        end
        if (word_end) begin
            s_d.shown = s_q.buf_full;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.ctrl <= scroll_pkg::CTRL_RESET;
            s_q.delay_reg <= scroll_pkg::DELAY_RESET;
            s_q.fstart <= scroll_pkg::FSTART_RESET;
            s_q.fstop <= scroll_pkg::FSTOP_RESET;
            s_q.fst <= FS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : playfield_scroll_fetch

// ==== hdl/scroll_pkg.sv ====
// Purpose: Shared constants and carrier types for the playfield scroll and fetch block.
// Assumes: APB with 32-bit data; one clock at the hires pixel rate.
// Notes:   Fetch positions are in colour clocks; one colour clock is four hires pixels.
package scroll_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [31:0] SCROLL_DELAY_IDX = 32'h00df_f102;
    localparam logic [31:0] SCROLL_DELAY_ADDR = {SCROLL_DELAY_IDX[29:0], 2'b00};
    localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
    localparam logic [31:0] FSTART_ADDR = 32'h0000_0004;
    localparam logic [31:0] FSTOP_ADDR = 32'h0000_0008;
    localparam logic [31:0] ODD_MOD_ADDR = 32'h0000_000c;
    localparam logic [31:0] EVEN_MOD_ADDR = 32'h0000_0010;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0014;
    localparam logic [31:0] PTR_BASE_ADDR = 32'h0000_0020;
    localparam logic [31:0] PTR_LAST_ADDR = 32'h0000_0034;

    // ************************************************************
    // Control fields and reset values
    // ************************************************************
    localparam int CTRL_DMA_EN = 0;
    localparam int CTRL_HIRES = 1;
    localparam int CTRL_EXTRA = 2;
    localparam int CTRL_NPL_LSB = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] DELAY_RESET = 16'h0000;
    localparam logic [7:0] FSTART_RESET = 8'h38;
    localparam logic [7:0] FSTOP_RESET = 8'hd0;

    // ************************************************************
    // Fetch and raster timing
    // ************************************************************
    localparam logic [7:0] FETCH_NORMAL = 8'h38;
    localparam logic [7:0] FETCH_MIN = 8'h18;
    localparam logic [7:0] FETCH_MAX = 8'hd8;
    localparam logic [7:0] LORES_UNIT = 8'h08;
    localparam logic [7:0] HIRES_UNIT = 8'h04;
    localparam logic [7:0] LINE_LAST = 8'he2;
    localparam logic [8:0] FIELD_LAST = 9'h105;
    localparam int PLANES = 6;
    localparam int FIFO_DEPTH = 16;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [2:0] plane;
        logic [15:0] data;
    } fetch_word_t;

    typedef struct packed {
        logic valid;
        logic [2:0] plane;
        logic [31:0] addr;
    } dma_req_t;

endpackage : scroll_pkg

// ==== hdl/word_fifo.sv ====
// Purpose: Synchronous FIFO carrying fetched plane words to the display side.
// Assumes: One clock; push and pop may share a cycle.
// Notes:   Full and empty are exact; pointers carry one wrap bit.
`timescale 1ns/1ps
module word_fifo #(
    parameter int W = 19,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_state_t;

    fifo_state_t s_q, s_d;
    logic full, empty;

    assign full = (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]) && (s_q.wp[AW] != s_q.rp[AW]);
    assign empty = (s_q.wp == s_q.rp);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = s_q.mem[s_q.rp[AW-1:0]];

    always_comb begin
        s_d = s_q;
        if (in_valid && !full) begin
            s_d.mem[s_q.wp[AW-1:0]] = in_data;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            s_d.rp = s_q.rp + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : word_fifo
